// ### design/adc_conversion_sequencer.v
`timescale 1ns/1ps
`include "adc_seq_map.vh"
module adc_conversion_sequencer #(
  parameter HALF_DIV = 4
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire trigger_i,
  input wire [2:0] sleep_mode_i,
  input wire cpu_halted_i,
  input wire scan_enable_i,
  input wire [9:0] sample_i,
  output reg sample_strobe_o,
  output reg [4:0] channel_select_o,
  output reg [1:0] reference_select_o,
  output reg converter_on_o,
  output reg conversion_done_irq_o,
  output reg [3:0] upper_pin_override_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [2:0] state;
  reg converter_enable_bit;
  reg auto_trigger_enable;
  reg free_run;
  reg irq_en;
  reg [4:0] chan_tmp;
  reg [1:0] ref_tmp;
  reg first_pending;
  reg half_rate_sync_clock;
  reg [4:0] conv_len;
  reg [4:0] sample_at;
  reg sample_on_rise;
  reg [4:0] conv_cnt;
  reg start_is_trig;
  reg [9:0] held_sample;
  reg [9:0] result;
  reg conversion_done_flag;
  reg halted_q;

  wire rise_tick;
  wire fall_tick;
  wire trig_edge;
  wire access;
  wire wr;
  wire busy;
  wire last_cycle;
  wire locked;
  wire is_diff;
  wire sleep_ok;
  wire sleep_start;
  wire start_write;
  wire trig_start;
  wire complete;

  assign access = psel_i & penable_i & ~pready_o;
  // Writes land on the edge that completes the transfer, with pready seen
  assign wr = psel_i & penable_i & pready_o & pwrite_i;
  assign busy = (state != ST_IDLE);
  assign last_cycle = (state == ST_CONV) && (conv_cnt == conv_len - 5'd1);
  // Frozen while converting; copying resumes in the final cycle
  assign locked = (state == ST_CONV) && !last_cycle;
  // Channel codes 8 and above take the differential gain path
  assign is_diff = (channel_select_o[4:3] != 2'b00);
  assign sleep_ok = (sleep_mode_i == `SLEEP_IDLE) ||
                    (sleep_mode_i == `SLEEP_NOISE_RED);
  // Only idle and noise-reduction sleep start a conversion
  assign sleep_start = cpu_halted_i & ~halted_q & sleep_ok &
                       converter_enable_bit & ~auto_trigger_enable &
                       (state == ST_IDLE);
  assign start_write = wr && (paddr_i == `OFS_CTRL) &&
                       pwdata_i[`CTRL_START] && pwdata_i[`CTRL_ENABLE];
  // Edges during a conversion are ignored
  assign trig_start = trig_edge & auto_trigger_enable & ~free_run &
                      converter_enable_bit & (state == ST_IDLE);
  assign complete = rise_tick && last_cycle;

  converter_clock_gen #(
    .HALF_DIV(HALF_DIV)
  ) u_clk (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .run_i(converter_enable_bit),
    .restart_i(trig_start),
    .rise_o(rise_tick),
    .fall_o(fall_tick)
  );

  trigger_edge_sync u_trig (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .trigger_i(trigger_i),
    .rise_o(trig_edge)
  );

  // Control, select and done flag writes
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_enable_bit <= 1'b0;
      auto_trigger_enable <= 1'b0;
      free_run <= 1'b0;
      irq_en <= 1'b0;
      chan_tmp <= `RST_CHAN;
      ref_tmp <= `RST_REF;
      conversion_done_flag <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      halted_q <= cpu_halted_i;
      if (wr && paddr_i == `OFS_CTRL) begin
        converter_enable_bit <= pwdata_i[`CTRL_ENABLE];
        auto_trigger_enable <= pwdata_i[`CTRL_AUTO];
        free_run <= pwdata_i[`CTRL_FREE_RUN];
        irq_en <= pwdata_i[`CTRL_IRQ_EN];
      end
      if (wr && paddr_i == `OFS_SELECT) begin
        chan_tmp <= pwdata_i[`SEL_CHAN_MSB:`SEL_CHAN_LSB];
        ref_tmp <= pwdata_i[`SEL_REF_MSB:`SEL_REF_LSB];
      end
      // A completion in the clearing cycle wins over the clear
      if (complete)
        conversion_done_flag <= 1'b1;
      else if (wr && paddr_i == `OFS_STATUS && pwdata_i[`STAT_DONE])
        conversion_done_flag <= 1'b0;
    end
  end

  // Half-rate clock follows converter rising edges, low while disabled
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i)
      half_rate_sync_clock <= 1'b0;
    else if (!converter_enable_bit)
      half_rate_sync_clock <= 1'b0;
    else if (rise_tick)
      half_rate_sync_clock <= ~half_rate_sync_clock;
  end

  // Conversion sequencer
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_IDLE;
      first_pending <= 1'b1;
      conv_len <= `LEN_NORMAL;
      sample_at <= `SMP_NORMAL;
      sample_on_rise <= 1'b0;
      conv_cnt <= 5'd0;
      start_is_trig <= 1'b0;
      held_sample <= 10'h000;
      result <= 10'h000;
      sample_strobe_o <= 1'b0;
    end else if (!converter_enable_bit && !start_write) begin
      // Disabling aborts and rearms the long first conversion; a write
      // that enables and starts at once falls through to the idle start
      state <= ST_IDLE;
      first_pending <= 1'b1;
      conv_cnt <= 5'd0;
      sample_strobe_o <= 1'b0;
    end else begin
      sample_strobe_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (trig_start) begin
            state <= ST_WAIT;
            start_is_trig <= 1'b1;
          end else if (start_write || sleep_start) begin
            state <= ST_WAIT;
            start_is_trig <= 1'b0;
          end
        end
        ST_WAIT: begin
          // Start lands on the next converter rising edge
          if (rise_tick) begin
            state <= ST_CONV;
            conv_cnt <= 5'd0;
            first_pending <= 1'b0;
            if (first_pending) begin
              conv_len <= `LEN_FIRST;
              sample_at <= `SMP_FIRST;
              sample_on_rise <= 1'b0;
            end else if (start_is_trig) begin
              conv_len <= `LEN_NORMAL;
              // Rise-tick match sees the count before it steps to two
              sample_at <= `SMP_TRIG - 5'd1;
              sample_on_rise <= 1'b1;
            end else if (is_diff && half_rate_sync_clock) begin
              conv_len <= `LEN_DIFF_LONG;
              sample_at <= `SMP_DIFF_LONG;
              sample_on_rise <= 1'b0;
            end else begin
              conv_len <= `LEN_NORMAL;
              sample_at <= `SMP_NORMAL;
              sample_on_rise <= 1'b0;
            end
          end
        end
        ST_CONV: begin
          if (rise_tick)
            conv_cnt <= conv_cnt + 5'd1;
          // Half-cycle sample points use the falling tick
          if (conv_cnt == sample_at &&
              (sample_on_rise ? rise_tick : fall_tick)) begin
            held_sample <= sample_i;
            sample_strobe_o <= 1'b1;
          end
          if (complete) begin
            result <= held_sample;
            conv_cnt <= 5'd0;
            if (auto_trigger_enable && free_run) begin
              // Restart at once; uses selection copied in the last cycle
              state <= ST_CONV;
              start_is_trig <= 1'b0;
              conv_len <= is_diff ? `LEN_DIFF_LONG : `LEN_NORMAL;
              sample_at <= is_diff ? `SMP_DIFF_LONG : `SMP_NORMAL;
              sample_on_rise <= 1'b0;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Active selection tracks the temporary copy unless locked
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      channel_select_o <= `RST_CHAN;
      reference_select_o <= `RST_REF;
    end else if (!locked) begin
      channel_select_o <= chan_tmp;
      reference_select_o <= ref_tmp;
    end
  end

  // Registered side outputs
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_on_o <= 1'b0;
      conversion_done_irq_o <= 1'b0;
      upper_pin_override_o <= 4'h0;
    end else begin
      converter_on_o <= converter_enable_bit;
      conversion_done_irq_o <= conversion_done_flag & irq_en;
      upper_pin_override_o <= {4{scan_enable_i}};
    end
  end

  // APB slave: one wait state, error on unmapped addresses
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= access;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
      if (access) begin
        if (paddr_i == `OFS_CTRL) begin
          prdata_o[`CTRL_ENABLE] <= converter_enable_bit;
          prdata_o[`CTRL_START] <= busy;
          prdata_o[`CTRL_AUTO] <= auto_trigger_enable;
          prdata_o[`CTRL_FREE_RUN] <= free_run;
          prdata_o[`CTRL_IRQ_EN] <= irq_en;
        end else if (paddr_i == `OFS_SELECT) begin
          prdata_o[`SEL_CHAN_MSB:`SEL_CHAN_LSB] <= chan_tmp;
          prdata_o[`SEL_REF_MSB:`SEL_REF_LSB] <= ref_tmp;
        end else if (paddr_i == `OFS_STATUS) begin
          prdata_o[`STAT_DONE] <= conversion_done_flag;
          prdata_o[`STAT_BUSY] <= busy;
          prdata_o[`STAT_LOCKED] <= locked;
        end else if (paddr_i == `OFS_RESULT) begin
          prdata_o[9:0] <= result;
        end else if (paddr_i == `OFS_ACTIVE) begin
          prdata_o[`SEL_CHAN_MSB:`SEL_CHAN_LSB] <= channel_select_o;
          prdata_o[`SEL_REF_MSB:`SEL_REF_LSB] <= reference_select_o;
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ### design/adc_seq_map.vh
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH

// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_SELECT 8'h04
`define OFS_STATUS 8'h08
`define OFS_RESULT 8'h0C
`define OFS_ACTIVE 8'h10

// Control register fields
`define CTRL_ENABLE 0
`define CTRL_START 1
`define CTRL_AUTO 2
`define CTRL_FREE_RUN 3
`define CTRL_IRQ_EN 4

// Select register fields
`define SEL_CHAN_LSB 0
`define SEL_CHAN_MSB 4
`define SEL_REF_LSB 6
`define SEL_REF_MSB 7

// Status register fields
`define STAT_DONE 0
`define STAT_BUSY 1
`define STAT_LOCKED 2

// Reset values
`define RST_CHAN 5'h00
`define RST_REF 2'h0

// Conversion lengths and sample points, in converter clock cycles
`define LEN_FIRST 5'd25
`define LEN_NORMAL 5'd13
`define LEN_DIFF_LONG 5'd14
`define SMP_FIRST 5'd13
`define SMP_NORMAL 5'd1
`define SMP_DIFF_LONG 5'd2
`define SMP_TRIG 5'd2

// Sleep mode codes seen on sleep_mode_i
`define SLEEP_IDLE 3'h0
`define SLEEP_NOISE_RED 3'h1

`endif

// ### design/converter_clock_gen.v
`timescale 1ns/1ps
// Prescaled converter clock as rise and fall tick pulses
module converter_clock_gen #(
  parameter HALF_DIV = 4
) (
  input wire clock_i,
  input wire rst_b_i,
  input wire run_i,
  input wire restart_i,
  output reg rise_o,
  output reg fall_o
);
  reg [7:0] cnt;
  reg phase;

  // Held in reset while disabled or on a trigger, for a fixed start delay
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 8'h00;
      phase <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (!run_i || restart_i) begin
      cnt <= 8'h00;
      phase <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else if (cnt == HALF_DIV[7:0] - 8'h01) begin
      cnt <= 8'h00;
      phase <= ~phase;
      rise_o <= ~phase;
      fall_o <= phase;
    end else begin
      cnt <= cnt + 8'h01;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end
  end
endmodule

// ### design/trigger_edge_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser plus edge register: three clocks of latency
module trigger_edge_sync (
  input wire clock_i,
  input wire rst_b_i,
  input wire trigger_i,
  output reg rise_o
);
  reg meta;
  reg stable;
  reg last;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= 1'b0;
      stable <= 1'b0;
      last <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      meta <= trigger_i;
      stable <= meta;
      last <= stable;
      rise_o <= stable & ~last;
    end
  end
endmodule

// ### dv/analog_front_model.sv
`timescale 1ns/1ps
// Input mux stand-in for the analog side, combinational with no sample-hold
module analog_front_model (
  input wire [4:0] channel_select_i,
  input wire [1:0] reference_select_i,
  output wire [9:0] sample_o
);
  // A distinct code for each selection, so a late or wrong mux shows
  assign sample_o = {reference_select_i, 3'h5, channel_select_i};
endmodule

// ### dv/adc_seq_monitor.sv
`timescale 1ns/1ps
// Port checks, one clock domain
module adc_seq_monitor (
  input wire clock_i,
  input wire rst_b_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire scan_enable_i,
  input wire sample_strobe_o,
  input wire [4:0] channel_select_o,
  input wire converter_on_o,
  input wire [3:0] upper_pin_override_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);
  // Bus answers after one wait state, for one cycle
  property p_ready_wait;
    psel_i && penable_i && !pready_o |=> pready_o;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no ready");
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready");
  // Outside the answer cycle the bus outputs sit at zero
  property p_idle;
    !pready_o |-> !pslverr_o && prdata_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not idle");
  property p_override;
    1'b1 |=> upper_pin_override_o == {4{$past(scan_enable_i)}};
  endproperty
  a_override: assert property (p_override) else $error("override");
  // Selection must not move around the sampling point
  property p_freeze;
    sample_strobe_o |-> $stable(channel_select_o)
      ##1 $stable(channel_select_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("channel moved");
  property p_strobe_pulse;
    sample_strobe_o |=> !sample_strobe_o;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe");
  property p_strobe_on;
    sample_strobe_o |-> converter_on_o;
  endproperty
  a_strobe_on: assert property (p_strobe_on) else $error("strobe off");
  // Enable follows the control write; never dropped by the device
  property p_on_copy;
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h00
      |-> ##2 converter_on_o == $past(pwdata_i[0], 2);
  endproperty
  a_on_copy: assert property (p_on_copy) else $error("enable copy");
endmodule

bind adc_conversion_sequencer adc_seq_monitor adc_seq_monitor_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .scan_enable_i(scan_enable_i),
  .sample_strobe_o(sample_strobe_o), .channel_select_o(channel_select_o),
  .converter_on_o(converter_on_o),
  .upper_pin_override_o(upper_pin_override_o)
);

// ### dv/adc_conversion_sequencer_tb_top.sv
`timescale 1ns/1ps
// APB master, mux stand-in, queued expectations
module adc_conversion_sequencer_tb_top;
  logic clock_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig = 1'b0;
  logic halted = 1'b0, scan = 1'b0, rd_ok;
  logic [2:0] sleep_mode = 3'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, seed = 32'h25A4, r;
  logic [64:0] rd_e;
  logic [64:0] exp_rd[$];
  logic [4:0] exp_ch[$];
  logic [4:0] ch_a, ch_b, ch_d;
  int gaps[$];
  int gap = 0, strobe_cnt = 0, error_cnt = 0, n_compared = 0, n, base;
  wire [31:0] prdata;
  wire pready, pslverr, strobe, conv_on, irq;
  wire [4:0] chan;
  wire [1:0] refsel;
  wire [3:0] ovr;
  wire [9:0] smp;

  // 4 ns clock
  initial begin
    forever #2 clock_i = ~clock_i;
  end

  adc_conversion_sequencer #(.HALF_DIV(1)) adc_conversion_sequencer_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .trigger_i(trig), .sleep_mode_i(sleep_mode),
    .cpu_halted_i(halted), .scan_enable_i(scan), .sample_i(smp),
    .sample_strobe_o(strobe), .channel_select_o(chan),
    .reference_select_o(refsel), .converter_on_o(conv_on),
    .conversion_done_irq_o(irq), .upper_pin_override_o(ovr)
  );
  analog_front_model analog_front_model_inst (
    .channel_select_i(chan), .reference_select_i(refsel), .sample_o(smp)
  );

  // Xorshift source with a fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Selection word (reference 1) and the code the mux then gives
  function automatic logic [31:0] sel(input logic [4:0] c);
    return {24'h0, 3'h2, c};
  endfunction
  function automatic logic [31:0] res(input logic [4:0] c);
    return {22'h0, 5'h0D, c};
  endfunction

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string s);
    n_compared++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, s);
    end
  endtask
  // A hung wait counts as a mismatch and ends the run
  task automatic hang(input string s);
    chk(1'b0, s);
    final_report();
  endtask
  // One transfer; a read notes its expectation, masked bits only
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m);
    int k;
    k = 0;
    if (!w) exp_rd.push_back({m, a > 8'h10, d});
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) hang("bus hang");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts edges until irq (1) or the strobe (0) is seen
  task automatic wait_hi(input logic which);
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while ((which ? irq : strobe) !== 1'b1 && n < 400);
    if (n >= 400) hang("wait hang");
  endtask
  task automatic wait_cnt(input int k);
    for (int i = 0; i < 400 && strobe_cnt < k; i++) @(posedge clock_i);
    if (strobe_cnt < k) hang("strobe hang");
  endtask

  // Watcher: strobe spacing, channel at sampling, read answers
  always @(posedge clock_i) begin
    gap = gap + 1;
    if (strobe === 1'b1) begin
      strobe_cnt++;
      gaps.push_back(gap);
      gap = 0;
      if (exp_ch.size() > 0) chk(chan === exp_ch.pop_front(), "chan");
    end
    if (pready === 1'b1 && pwrite === 1'b0 && exp_rd.size() > 0) begin
      rd_e = exp_rd.pop_front();
      rd_ok = (prdata & rd_e[64:33]) === (rd_e[31:0] & rd_e[64:33]);
      chk(rd_ok && pslverr === rd_e[32], "read");
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    r = rnd();
    ch_a = {2'b00, r[2:0]};
    ch_b = ch_a ^ 5'h01;
    ch_d = {2'b01, r[8:6]};
    apb(1'b0, 8'h14, 32'h0, 32'hFFFFFFFF);
    apb(1'b0, 8'h04, 32'h0, 32'hFF);
    scan <= r[9];
    apb(1'b1, 8'h04, sel(ch_a), 32'h0);
    apb(1'b0, 8'h10, sel(ch_a), 32'hDF);
    exp_ch.push_back(ch_a);
    apb(1'b1, 8'h00, 32'h13, 32'h0);
    wait_hi(1'b0);
    chk(n >= 26 && n <= 32, "first");
    apb(1'b1, 8'h04, sel(ch_b), 32'h0);
    apb(1'b0, 8'h10, sel(ch_a), 32'hDF);
    apb(1'b0, 8'h00, 32'h2, 32'h2);
    wait_hi(1'b1);
    apb(1'b0, 8'h0C, res(ch_a), 32'h3FF);
    apb(1'b0, 8'h08, 32'h1, 32'h3);
    apb(1'b0, 8'h00, 32'h11, 32'h1F);
    apb(1'b0, 8'h10, sel(ch_b), 32'hDF);
    apb(1'b1, 8'h08, 32'h1, 32'h0);
    exp_ch.push_back(ch_b);
    apb(1'b1, 8'h00, 32'h13, 32'h0);
    wait_hi(1'b0);
    chk(n >= 2 && n <= 8, "normal");
    wait_hi(1'b1);
    apb(1'b1, 8'h08, 32'h1, 32'h0);
    $display("test single done");
    scan <= ~r[9];
    // Free run: change after first completion reaches the third only
    apb(1'b1, 8'h04, sel(ch_a), 32'h0);
    exp_ch = '{ch_a, ch_a, ch_b};
    gaps.delete();
    base = strobe_cnt;
    apb(1'b1, 8'h00, 32'h1F, 32'h0);
    wait_hi(1'b1);
    apb(1'b1, 8'h04, sel(ch_b), 32'h0);
    wait_cnt(base + 3);
    chk(gaps[1] == 26 && gaps[2] == 26, "run gap");
    // Enable toggled around differential work
    apb(1'b1, 8'h00, 32'h0, 32'h0);
    apb(1'b1, 8'h04, sel(ch_d), 32'h0);
    exp_ch = '{ch_d, ch_d, ch_d};
    gaps.delete();
    base = strobe_cnt;
    apb(1'b1, 8'h00, 32'h1F, 32'h0);
    wait_cnt(base + 3);
    chk(gaps[1] == 28 && gaps[2] == 28, "diff gap");
    apb(1'b1, 8'h00, 32'h0, 32'h0);
    // Free-run completions left the done flag up; clear it before waiting
    apb(1'b1, 8'h08, 32'h1, 32'h0);
    $display("test free run done");
    apb(1'b1, 8'h04, sel(ch_a), 32'h0);
    apb(1'b1, 8'h00, 32'h13, 32'h0);
    wait_hi(1'b1);
    apb(1'b1, 8'h08, 32'h1, 32'h0);
    apb(1'b1, 8'h00, 32'h15, 32'h0);
    trig <= 1'b1;
    wait_hi(1'b0);
    chk(n >= 6 && n <= 12, "trigger");
    trig <= 1'b0;
    @(posedge clock_i);
    trig <= 1'b1;
    base = strobe_cnt;
    wait_hi(1'b1);
    repeat (40) @(posedge clock_i);
    chk(strobe_cnt == base, "busy edge");
    trig <= 1'b0;
    apb(1'b1, 8'h08, 32'h1, 32'h0);
    apb(1'b1, 8'h00, 32'h11, 32'h0);
    sleep_mode <= 3'h3;
    halted <= 1'b1;
    repeat (40) @(posedge clock_i);
    chk(strobe_cnt == base && conv_on === 1'b1, "other sleep");
    halted <= 1'b0;
    r = rnd();
    @(posedge clock_i);
    sleep_mode <= {2'b00, r[0]};
    halted <= 1'b1;
    wait_hi(1'b0);
    halted <= 1'b0;
    wait_hi(1'b1);
    apb(1'b0, 8'h08, 32'h1, 32'h1);
    $display("test trigger and sleep done");
    // Let the watcher take the last read answer before the verdict
    repeat (2) @(posedge clock_i);
    final_report();
  end
endmodule
